/* shared/quad_counter_params.svh */
// Summary of operation
// - mode 0 counts up on each of the four edges while phase A leads
// - mode 0 counts down on each of the four edges while phase A lags
// - mode 1 counts on A rising only: up with B low, down with B high
// - mode 2 counts up on A rising while B is low
// - mode 2 counts down on B rising while A is low; other edges ignored
// - mode 3 counts on B edges only: up on B rise/A high or B fall/A low
// - mode 3 counts down on B rise/A low or B fall/A high
// - a rising index input clears the count to zero while counting runs and the index function is selected
// - index clear only on the index terminal; otherwise a plain input
// - after an index clear took effect the clear-done flag (bit 1) sets
// - clear-done drops once the acknowledge flag is seen on
// - only bit 1 of the done and acknowledge words carry this handshake
// - phase A comes from terminal X0 of group 1, phase B from X2 of group 2
// - exactly four decoding modes, numbered 0 through 3
`ifndef QUAD_COUNTER_PARAMS_SVH
`define QUAD_COUNTER_PARAMS_SVH
`define QC_AW 8
`define QC_DW 32
`define QC_CTRL_OFS 8'h00
`define QC_COUNT_OFS 8'h04
`define QC_DONE_OFS 8'h08
`define QC_ACK_OFS 8'h0C
`define QC_IRQ_STAT_OFS 8'h10
`define QC_IRQ_MASK_OFS 8'h14
`define QC_INPUT_OFS 8'h18
`define QC_MODE_LSB 0
`define QC_MODE_MSB 1
`define QC_RUN_BIT 4
`define QC_IDX_SEL_BIT 5
`define QC_HS_BIT 1
`define QC_IN_A_BIT 0
`define QC_IN_B_BIT 1
`define QC_IN_Z_BIT 2
`define QC_EV_CLR_BIT 0
`define QC_EV_WRAP_BIT 1
`define QC_RESP_OKAY 2'h0
`define QC_RESP_DECERR 2'h3
`define QC_ALIGN_MASK 8'hFC
`define QC_ONE 32'h1
`endif

/* shared/quad_pkg.sv */
package quad_pkg;
  typedef enum logic [1:0] {QM_FULL, QM_A_RISE, QM_RISE_EACH, QM_B_EDGES} qmode_e;
  typedef struct packed {
    logic a1, a2, ad, b1, b2, bd, z1, z2, zd;
    qmode_e mode;
    logic run;
    logic idx_sel;
    logic [31:0] count;
    logic clr_pend;
    logic done;
    logic ack;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qstate_s;
endpackage

/* verilog/quad_counter.sv */
`timescale 1ns/100ps
`include "quad_counter_params.svh"
module quad_counter import quad_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic phase_a_terminal,
  input wire logic phase_b_terminal,
  input wire logic index_terminal,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic [31:0] count_value
);
  qstate_s s_ff;
  qstate_s nxt_s;
  logic ar_e, af_e, br_e, bf_e, zr_e;
  logic a_ev, b_ev, one_ev;
  logic up, dn;
  logic idx_evt;
  logic [1:0] ev;
  logic [7:0] wa;
  logic [7:0] ra;
  logic ar_fire;
  logic wr_go;

  // edges from the 2nd sync stage and its delayed copy only
  assign ar_e = s_ff.a2 & ~s_ff.ad;
  assign af_e = ~s_ff.a2 & s_ff.ad;
  assign br_e = s_ff.b2 & ~s_ff.bd;
  assign bf_e = ~s_ff.b2 & s_ff.bd;
  assign zr_e = s_ff.z2 & ~s_ff.zd;
  assign a_ev = ar_e | af_e;
  assign b_ev = br_e | bf_e;
  // both phases moving in one sample is a glitch: direction unknown, dropped
  assign one_ev = a_ev ^ b_ev;

  assign awready = ~s_ff.aw_held & ~s_ff.bvalid;
  assign wready = ~s_ff.w_held & ~s_ff.bvalid;
  assign arready = ~s_ff.rvalid;
  assign ar_fire = arvalid & arready;
  assign wr_go = s_ff.aw_held & s_ff.w_held;
  assign wa = s_ff.awaddr & `QC_ALIGN_MASK;
  assign ra = araddr & `QC_ALIGN_MASK;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign count_value = s_ff.count;
  assign irq = |(s_ff.irq_stat & s_ff.irq_mask);

  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    case (s_ff.mode)
      QM_FULL: begin
        up = (br_e & s_ff.a2) | (bf_e & ~s_ff.a2)
          | (af_e & s_ff.b2) | (ar_e & ~s_ff.b2);
        dn = (br_e & ~s_ff.a2) | (bf_e & s_ff.a2)
          | (af_e & ~s_ff.b2) | (ar_e & s_ff.b2);
      end
      QM_A_RISE: begin
        up = ar_e & ~s_ff.b2;
        dn = ar_e & s_ff.b2;
      end
      QM_RISE_EACH: begin
        up = ar_e & ~s_ff.b2;
        dn = br_e & ~s_ff.a2;
      end
      QM_B_EDGES: begin
        up = (br_e & s_ff.a2) | (bf_e & ~s_ff.a2);
        dn = (br_e & ~s_ff.a2) | (bf_e & s_ff.a2);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    up = up & one_ev;
    dn = dn & one_ev;
  end

  // index terminal only clears when its function is selected
  assign idx_evt = s_ff.run & s_ff.idx_sel & zr_e;

  always_comb begin
    nxt_s = s_ff;
    ev = 2'h0;
    // two-stage synchronisers plus one delay stage for edges
    nxt_s.a1 = phase_a_terminal;
    nxt_s.a2 = s_ff.a1;
    nxt_s.ad = s_ff.a2;
    nxt_s.b1 = phase_b_terminal;
    nxt_s.b2 = s_ff.b1;
    nxt_s.bd = s_ff.b2;
    nxt_s.z1 = index_terminal;
    nxt_s.z2 = s_ff.z1;
    nxt_s.zd = s_ff.z2;

    nxt_s.clr_pend = 1'b0;
    if (idx_evt) begin
      nxt_s.count = '0;
      nxt_s.clr_pend = 1'b1;
      ev[`QC_EV_CLR_BIT] = 1'b1;
    end else if (s_ff.run && up) begin
      nxt_s.count = s_ff.count + `QC_ONE;
      ev[`QC_EV_WRAP_BIT] = &s_ff.count;
    end else if (s_ff.run && dn) begin
      nxt_s.count = s_ff.count - `QC_ONE;
      ev[`QC_EV_WRAP_BIT] = ~|s_ff.count;
    end

    // done rises the cycle after the zeroed count is visible; set beats drop
    if (s_ff.clr_pend) begin
      nxt_s.done = 1'b1;
    end else if (s_ff.ack) begin
      nxt_s.done = 1'b0;
    end

    if (awvalid && awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.wdata = wdata;
      nxt_s.wstrb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `QC_RESP_OKAY;
      case (wa)
        `QC_CTRL_OFS: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.run = s_ff.wdata[`QC_RUN_BIT];
            nxt_s.idx_sel = s_ff.wdata[`QC_IDX_SEL_BIT];
            // mode frozen while running so decoding never switches mid-count
            if (!s_ff.run) begin
              nxt_s.mode = qmode_e'(s_ff.wdata[`QC_MODE_MSB:`QC_MODE_LSB]);
            end
          end
        end
        `QC_ACK_OFS: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.ack = s_ff.wdata[`QC_HS_BIT];
          end
        end
        `QC_IRQ_MASK_OFS: begin
          if (s_ff.wstrb[0]) begin
            nxt_s.irq_mask = s_ff.wdata[1:0];
          end
        end
        `QC_COUNT_OFS, `QC_DONE_OFS, `QC_IRQ_STAT_OFS, `QC_INPUT_OFS: begin
          nxt_s.bresp = `QC_RESP_OKAY;
        end
        default: begin
          nxt_s.bresp = `QC_RESP_DECERR;
        end
      endcase
    end

    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = '0;
      nxt_s.rresp = `QC_RESP_OKAY;
      case (ra)
        `QC_CTRL_OFS: begin
          nxt_s.rdata[`QC_MODE_MSB:`QC_MODE_LSB] = s_ff.mode;
          nxt_s.rdata[`QC_RUN_BIT] = s_ff.run;
          nxt_s.rdata[`QC_IDX_SEL_BIT] = s_ff.idx_sel;
        end
        `QC_COUNT_OFS: begin
          nxt_s.rdata = s_ff.count;
        end
        `QC_DONE_OFS: begin
          nxt_s.rdata[`QC_HS_BIT] = s_ff.done;
        end
        `QC_ACK_OFS: begin
          nxt_s.rdata[`QC_HS_BIT] = s_ff.ack;
        end
        `QC_IRQ_STAT_OFS: begin
          nxt_s.rdata[1:0] = s_ff.irq_stat;
        end
        `QC_IRQ_MASK_OFS: begin
          nxt_s.rdata[1:0] = s_ff.irq_mask;
        end
        `QC_INPUT_OFS: begin
          // index terminal read here as a plain input level
          nxt_s.rdata[`QC_IN_A_BIT] = s_ff.a2;
          nxt_s.rdata[`QC_IN_B_BIT] = s_ff.b2;
          nxt_s.rdata[`QC_IN_Z_BIT] = s_ff.z2;
        end
        default: begin
          nxt_s.rresp = `QC_RESP_DECERR;
        end
      endcase
    end

    // read clears, but an event in the same cycle survives
    if (ar_fire && ra == `QC_IRQ_STAT_OFS) begin
      nxt_s.irq_stat = ev;
    end else begin
      nxt_s.irq_stat = s_ff.irq_stat | ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  idx_clear_a: assert property (idx_evt |=> s_ff.count == '0)
    else $error("index did not clear count");
  idx_plain_a: assert property (!s_ff.idx_sel |=> !s_ff.clr_pend)
    else $error("clear without index function");
  done_set_a: assert property (idx_evt |=> ##1 s_ff.done)
    else $error("done not set after clear");
  done_drop_a: assert property (s_ff.done && s_ff.ack && !s_ff.clr_pend |=> !s_ff.done)
    else $error("done held after acknowledge");
  full_up_a: assert property (s_ff.run && s_ff.mode == QM_FULL && br_e && s_ff.a2
    && !a_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 0 missed up count");
  full_arise_a: assert property (s_ff.run && s_ff.mode == QM_FULL && ar_e
    && !s_ff.b2 && !b_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 0 missed up count on A rise");
  full_bfall_a: assert property (s_ff.run && s_ff.mode == QM_FULL && bf_e
    && !s_ff.a2 && !a_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 0 missed up count on B fall");
  full_dn_a: assert property (s_ff.run && s_ff.mode == QM_FULL && af_e && !s_ff.b2
    && !b_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) - `QC_ONE)
    else $error("mode 0 missed down count");
  arise_hold_a: assert property (s_ff.mode == QM_A_RISE && !ar_e && !idx_evt
    |=> $stable(s_ff.count))
    else $error("mode 1 counted off A rise");
  arise_up_a: assert property (s_ff.run && s_ff.mode == QM_A_RISE && ar_e
    && !s_ff.b2 && !b_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 1 missed up count");
  arise_dn_a: assert property (s_ff.run && s_ff.mode == QM_A_RISE && ar_e
    && s_ff.b2 && !b_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) - `QC_ONE)
    else $error("mode 1 missed down count");
  each_up_a: assert property (s_ff.run && s_ff.mode == QM_RISE_EACH && ar_e
    && !s_ff.b2 && !b_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 2 missed up count");
  each_dn_a: assert property (s_ff.run && s_ff.mode == QM_RISE_EACH && br_e
    && !s_ff.a2 && !a_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) - `QC_ONE)
    else $error("mode 2 missed down count");
  each_hold_a: assert property (s_ff.mode == QM_RISE_EACH && !ar_e && !br_e
    && !idx_evt |=> $stable(s_ff.count))
    else $error("mode 2 counted on a falling edge");
  bedge_ign_a: assert property (s_ff.mode == QM_B_EDGES && !b_ev && !idx_evt
    |=> $stable(s_ff.count))
    else $error("mode 3 counted on A edge");
  bedge_up_a: assert property (s_ff.run && s_ff.mode == QM_B_EDGES && br_e
    && s_ff.a2 && !a_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) + `QC_ONE)
    else $error("mode 3 missed up count");
  bedge_dn_a: assert property (s_ff.run && s_ff.mode == QM_B_EDGES && bf_e
    && s_ff.a2 && !a_ev && !idx_evt |=> s_ff.count == $past(s_ff.count) - `QC_ONE)
    else $error("mode 3 missed down count");
  sync_lat_a: assert property ($rose(s_ff.a2) |-> $past(phase_a_terminal, 2))
    else $error("phase A sync depth wrong");
  mode_hold_a: assert property (s_ff.run |=> $stable(s_ff.mode))
    else $error("mode changed while running");
  done_hold_a: assert property (s_ff.done && !s_ff.ack |=> s_ff.done)
    else $error("done dropped without acknowledge");
  idle_hold_a: assert property (!s_ff.run |=> $stable(s_ff.count))
    else $error("count moved while stopped");

  idx_hs_c: cover property (idx_evt ##2 s_ff.done ##[1:50] !s_ff.done);
  wrap_c: cover property (s_ff.run && up && &s_ff.count);
  mode3_c: cover property (s_ff.run && s_ff.mode == QM_B_EDGES && dn);
  mode1_c: cover property (s_ff.run && s_ff.mode == QM_A_RISE && dn);
  stat_rd_c: cover property (ar_fire && ra == `QC_IRQ_STAT_OFS && |s_ff.irq_stat);
endmodule

/* bench/quad_encoder.sv */
`timescale 1ns/100ps
module quad_encoder (
  input wire logic sys_clk,
  output logic phase_a,
  output logic phase_b,
  output logic index_pulse
);
  initial begin
    phase_a = 1'h0;
    phase_b = 1'h0;
    index_pulse = 1'h0;
  end
  // one level change per call; a gap of 2 is the fastest legal rate
  task automatic move(input logic na, input logic nb, input int gap);
    @(posedge sys_clk);
    phase_a <= na;
    phase_b <= nb;
    repeat (gap) @(posedge sys_clk);
  endtask
  // forward walks 00,10,11,01,00 so phase A leads
  task automatic spin(input logic fwd, input int gap);
    if (fwd) begin
      move(1'h1, 1'h0, gap);
      move(1'h1, 1'h1, gap);
      move(1'h0, 1'h1, gap);
    end else begin
      move(1'h0, 1'h1, gap);
      move(1'h1, 1'h1, gap);
      move(1'h1, 1'h0, gap);
    end
    move(1'h0, 1'h0, gap);
    // sync and edge pipeline needs three edges to land
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic index_level(input logic lv);
    @(posedge sys_clk);
    index_pulse <= lv;
  endtask
endmodule

/* bench/quad_counter_tb.sv */
`timescale 1ns/100ps
`include "quad_counter_params.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module quad_counter_tb;
  logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, irq;
  logic awready, wready, bvalid, arready, rvalid, pa, pb, pz;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, count_value, want, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, wresp;
  logic [31:0] stp [4] = '{32'h4, 32'h1, 32'h1, 32'h2};
  int num_errors, checked, cyc;
  quad_encoder u_quad_encoder (.sys_clk(sys_clk), .phase_a(pa), .phase_b(pb),
    .index_pulse(pz));
  quad_counter u_quad_counter (.sys_clk(sys_clk), .rst_n(rst_n), .phase_a_terminal(pa),
    .phase_b_terminal(pb), .index_terminal(pz), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .count_value(count_value));
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard; the full run needs well under a tenth of this
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh;
    ah = 1'h0;
    wh = 1'h0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ah && wh)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        ah = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wh = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge sys_clk);
    wresp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge sys_clk);
    while (!arready) @(posedge sys_clk);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge sys_clk);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK("register", e, d)
  endtask
  initial begin
    rst_n = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    want = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    rdc(`QC_CTRL_OFS, 32'h0);
    rdc(`QC_COUNT_OFS, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(`QC_CTRL_OFS, 32'h0);
      wr(`QC_CTRL_OFS, 32'(m));
      wr(`QC_CTRL_OFS, 32'h10 | 32'(m));
      u_quad_encoder.spin(1'h1, m[0] ? 2 : 6);
      want = want + stp[m];
      rdc(`QC_COUNT_OFS, want);
      u_quad_encoder.spin(1'h0, 6);
      u_quad_encoder.spin(1'h0, 2);
      want = want - 2 * stp[m];
      rdc(`QC_COUNT_OFS, want);
    end
    wr(`QC_CTRL_OFS, 32'h10);
    rdc(`QC_CTRL_OFS, 32'h13);
    wr(`QC_IRQ_MASK_OFS, 32'h1);
    wr(`QC_CTRL_OFS, 32'h33);
    u_quad_encoder.spin(1'h1, 2);
    u_quad_encoder.index_level(1'h1);
    repeat (6) @(posedge sys_clk);
    `CHK("count", 32'h0, count_value)
    `CHK("irq", 1'h1, irq)
    rdc(`QC_DONE_OFS, 32'h2);
    rd(`QC_IRQ_STAT_OFS, d, r);
    `CHK("irq status", 32'h3, d)
    repeat (2) @(posedge sys_clk);
    `CHK("irq", 1'h0, irq)
    wr(`QC_ACK_OFS, 32'hFFFFFFFF);
    `CHK("write response", `QC_RESP_OKAY, wresp)
    rdc(`QC_ACK_OFS, 32'h2);
    rdc(`QC_DONE_OFS, 32'h0);
    wr(`QC_ACK_OFS, 32'h0);
    u_quad_encoder.index_level(1'h0);
    wr(`QC_CTRL_OFS, 32'h13);
    u_quad_encoder.spin(1'h1, 2);
    u_quad_encoder.index_level(1'h1);
    repeat (6) @(posedge sys_clk);
    rdc(`QC_INPUT_OFS, 32'h4);
    `CHK("count", 32'h2, count_value)
    rdc(`QC_DONE_OFS, 32'h0);
    u_quad_encoder.index_level(1'h0);
    rd(8'h40, d, r);
    `CHK("response", `QC_RESP_DECERR, r)
    wr(8'h40, 32'h0);
    `CHK("write response", `QC_RESP_DECERR, wresp)
    results();
  end
endmodule
